// ### hw/dcar_top.v
// clear-source and alarm-pin routing registers with an axi4-lite slave
//
// What this block does
// - enabled dac enters clear on clear event
// - disabled dac ignores clear events
// - enable bits map groups a-d to dacs 0-15
// - only enable bits pick which dacs clear
// - clear applies in auto and manual modes
// - dac clears only if own enable set
// - adc source register: inputs 16-20, bits 7-5 zero
// - misc source register: external, thermal, temp high/low
// - pin source register: inputs 16-20 to pin
// - pin sources inert unless pin function enabled
// - all routing registers reset to zero
// - shared pin: general io or alarm output
// - flags latched until read, unless latch disabled
`timescale 1ns/1ps
`default_nettype none
`include "dcar_consts.vh"

module dcar_top (
    // clock and reset
    input wire clk,
    input wire sys_rst,
    // axi4-lite write address
    input wire [`DCAR_ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    // axi4-lite write data
    input wire [`DCAR_DATA_W-1:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // axi4-lite write response
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    // axi4-lite read address
    input wire [`DCAR_ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    // axi4-lite read data
    output wire [`DCAR_DATA_W-1:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready,
    // alarm conditions from the converter, same clock
    input wire [`DCAR_ADC_ALARMS-1:0] adc_alarm_cond,
    input wire thermal_alarm_cond,
    input wire local_temp_high_cond,
    input wire local_temp_low_cond,
    // external alarm pin, asynchronous
    input wire alarm_input_pin,
    // general-purpose drive for the shared pin, same clock
    input wire general_io_one_o,
    input wire general_io_one_oe,
    // shared pin drive
    output wire alarm_output_pin_o,
    output wire alarm_output_pin_oe,
    // per-dac clear commands
    output wire [`DCAR_DACS-1:0] dac_clear
);

    ////////////////////////////////////////////////////////////////////////
    // register file

    reg [7:0] clren_lo_ff;
    reg [7:0] clren_hi_ff;
    reg [7:0] csrc_adc_ff;
    reg [7:0] csrc_misc_ff;
    reg [7:0] psrc_adc_ff;
    reg pin_fn_en_ff;
    reg latch_dis_ff;

    ////////////////////////////////////////////////////////////////////////
    // bus handshake state

    reg awready_ff;
    reg wready_ff;
    reg bvalid_ff;
    reg [1:0] bresp_ff;
    reg aw_held_ff;
    reg w_held_ff;
    reg [`DCAR_ADDR_W-1:0] waddr_ff;
    reg [`DCAR_DATA_W-1:0] wdata_ff;
    reg wstrb0_ff;
    reg arready_ff;
    reg rvalid_ff;
    reg [1:0] rresp_ff;
    reg [`DCAR_DATA_W-1:0] rdata_ff;

    wire aw_hs;
    wire w_hs;
    wire ar_hs;
    wire do_write;
    wire [7:0] widx;
    wire [7:0] ridx;
    wire wr_hit;

    assign aw_hs = s_axi_awvalid & awready_ff;
    assign w_hs = s_axi_wvalid & wready_ff;
    assign ar_hs = s_axi_arvalid & arready_ff;
    assign do_write = aw_held_ff & w_held_ff & ~bvalid_ff;
    // word index, widened to the width of the index constants
    assign widx = {2'b00, waddr_ff[7:2]};
    assign ridx = {2'b00, s_axi_araddr[7:2]};

    // writable registers only; read-only words answer an error on write
    assign wr_hit = (widx == `DCAR_IDX_GPIO_CFG) |
                    (widx == `DCAR_IDX_CLREN_LO) |
                    (widx == `DCAR_IDX_CLREN_HI) |
                    (widx == `DCAR_IDX_CSRC_ADC) |
                    (widx == `DCAR_IDX_CSRC_MISC) |
                    (widx == `DCAR_IDX_PSRC_ADC) |
                    (widx == `DCAR_IDX_PSRC_MISC);

    ////////////////////////////////////////////////////////////////////////
    // write channel: address and data taken in either order

    always @(posedge clk) begin
        if (sys_rst) begin
            awready_ff <= 1'b1;
            wready_ff <= 1'b1;
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= `DCAR_RESP_OKAY;
            waddr_ff <= {`DCAR_ADDR_W{1'b0}};
            wdata_ff <= {`DCAR_DATA_W{1'b0}};
            wstrb0_ff <= 1'b0;
        end else begin
            if (aw_hs) begin
                aw_held_ff <= 1'b1;
                awready_ff <= 1'b0;
                waddr_ff <= s_axi_awaddr;
            end
            if (w_hs) begin
                w_held_ff <= 1'b1;
                wready_ff <= 1'b0;
                wdata_ff <= s_axi_wdata;
                wstrb0_ff <= s_axi_wstrb[0];
            end
            if (do_write) begin
                aw_held_ff <= 1'b0;
                w_held_ff <= 1'b0;
                bvalid_ff <= 1'b1;
                bresp_ff <= wr_hit ? `DCAR_RESP_OKAY : `DCAR_RESP_SLVERR;
            end
            // ready only reopens once the response is gone: one write at a time
            if (bvalid_ff & s_axi_bready) begin
                bvalid_ff <= 1'b0;
                awready_ff <= 1'b1;
                wready_ff <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register updates; only byte lane 0 carries data

    always @(posedge clk) begin
        if (sys_rst) begin
            clren_lo_ff <= `DCAR_RST_REG;
            clren_hi_ff <= `DCAR_RST_REG;
            csrc_adc_ff <= `DCAR_RST_REG;
            csrc_misc_ff <= `DCAR_RST_REG;
            psrc_adc_ff <= `DCAR_RST_REG;
            pin_fn_en_ff <= 1'b0;
            latch_dis_ff <= 1'b0;
        end else if (do_write & wstrb0_ff) begin
            case (widx)
                `DCAR_IDX_GPIO_CFG: pin_fn_en_ff <= wdata_ff[`DCAR_BIT_PIN_FN_EN];
                `DCAR_IDX_CLREN_LO: clren_lo_ff <= wdata_ff[7:0];
                `DCAR_IDX_CLREN_HI: clren_hi_ff <= wdata_ff[7:0];
                `DCAR_IDX_CSRC_ADC: begin
                    csrc_adc_ff <= wdata_ff[7:0] & `DCAR_MASK_CSRC_ADC;
                end
                `DCAR_IDX_CSRC_MISC: begin
                    csrc_misc_ff <= wdata_ff[7:0] & `DCAR_MASK_CSRC_MISC;
                end
                `DCAR_IDX_PSRC_ADC: begin
                    psrc_adc_ff <= wdata_ff[7:0] & `DCAR_MASK_PSRC_ADC;
                end
                `DCAR_IDX_PSRC_MISC: latch_dis_ff <= wdata_ff[`DCAR_BIT_LATCH_DIS];
                default: latch_dis_ff <= latch_dis_ff;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // external alarm pin: three flops, a change counts once two agree

    reg ext_s1_ff;
    reg ext_s2_ff;
    reg ext_s3_ff;
    reg ext_level_ff;

    always @(posedge clk) begin
        if (sys_rst) begin
            ext_s1_ff <= 1'b0;
            ext_s2_ff <= 1'b0;
            ext_s3_ff <= 1'b0;
            ext_level_ff <= 1'b0;
        end else begin
            ext_s1_ff <= alarm_input_pin;
            ext_s2_ff <= ext_s1_ff;
            ext_s3_ff <= ext_s2_ff;
            if (ext_s2_ff == ext_s3_ff) begin
                ext_level_ff <= ext_s3_ff;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // alarm flags; order matches the source registers

    wire [`DCAR_ALL_ALARMS-1:0] alarm_cond;
    wire [`DCAR_ALL_ALARMS-1:0] flags;
    wire flag_rd_clr;

    // misc alarms sit above the five converter alarms
    assign alarm_cond = {ext_level_ff, thermal_alarm_cond,
                         local_temp_high_cond, local_temp_low_cond,
                         adc_alarm_cond};

    // reading the flag word is what releases a latched flag
    assign flag_rd_clr = ar_hs & (ridx == `DCAR_IDX_FLAGS);

    dcar_flags #(
        .N(`DCAR_ALL_ALARMS)
    ) u_flags (
        .clk(clk),
        .sys_rst(sys_rst),
        .latch_dis(latch_dis_ff),
        .read_clr(flag_rd_clr),
        .cond(alarm_cond),
        .flags(flags)
    );

    ////////////////////////////////////////////////////////////////////////
    // clear event and pin request from the selected flags

    wire [`DCAR_ALL_ALARMS-1:0] clr_sel;
    wire clear_event;
    wire pin_alarm;
    wire [`DCAR_DACS-1:0] clr_en;

    assign clr_sel = {csrc_misc_ff[`DCAR_MISC_ALARMS-1:0],
                      csrc_adc_ff[`DCAR_ADC_ALARMS-1:0]};
    assign clear_event = |(flags & clr_sel);
    // only the converter alarms are routed to the pin here
    assign pin_alarm = |(flags[`DCAR_ADC_ALARMS-1:0] &
                         psrc_adc_ff[`DCAR_ADC_ALARMS-1:0]);
    // group a/b in the low register, c/d in the high one
    assign clr_en = {clren_hi_ff, clren_lo_ff};

    ////////////////////////////////////////////////////////////////////////
    // per-dac clear; no mode input, so it holds in auto and manual alike

    reg [`DCAR_DACS-1:0] dac_clear_ff;

    genvar d;
    generate
        for (d = 0; d < `DCAR_DACS; d = d + 1) begin : g_dac
            always @(posedge clk) begin
                if (sys_rst) begin
                    dac_clear_ff[d] <= 1'b0;
                end else begin
                    // enable bit alone picks the dac
                    dac_clear_ff[d] <= clear_event & clr_en[d];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // shared pin: general io by default, alarm output when enabled

    reg pin_o_ff;
    reg pin_oe_ff;

    always @(posedge clk) begin
        if (sys_rst) begin
            pin_o_ff <= 1'b0;
            pin_oe_ff <= 1'b0;
        end else if (pin_fn_en_ff) begin
            // alarm drive is active high and always enabled
            pin_o_ff <= pin_alarm;
            pin_oe_ff <= 1'b1;
        end else begin
            // selected sources are ignored while the pin is general io
            pin_o_ff <= general_io_one_o;
            pin_oe_ff <= general_io_one_oe;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read channel: data registered at the address handshake

    reg [`DCAR_DATA_W-1:0] rd_mux;
    reg rd_hit;

    // flag word returns the value before the clear takes effect
    always @* begin
        rd_mux = {`DCAR_DATA_W{1'b0}};
        rd_hit = 1'b1;
        case (ridx)
            `DCAR_IDX_GPIO_CFG: rd_mux[`DCAR_BIT_PIN_FN_EN] = pin_fn_en_ff;
            `DCAR_IDX_CLREN_LO: rd_mux[7:0] = clren_lo_ff;
            `DCAR_IDX_CLREN_HI: rd_mux[7:0] = clren_hi_ff;
            `DCAR_IDX_CSRC_ADC: rd_mux[7:0] = csrc_adc_ff;
            `DCAR_IDX_CSRC_MISC: rd_mux[7:0] = csrc_misc_ff;
            `DCAR_IDX_PSRC_ADC: rd_mux[7:0] = psrc_adc_ff;
            `DCAR_IDX_PSRC_MISC: rd_mux[`DCAR_BIT_LATCH_DIS] = latch_dis_ff;
            `DCAR_IDX_FLAGS: rd_mux[`DCAR_ALL_ALARMS-1:0] = flags;
            `DCAR_IDX_CLR_STATE: rd_mux[`DCAR_DACS-1:0] = dac_clear_ff;
            default: rd_hit = 1'b0;
        endcase
    end

    always @(posedge clk) begin
        if (sys_rst) begin
            arready_ff <= 1'b1;
            rvalid_ff <= 1'b0;
            rresp_ff <= `DCAR_RESP_OKAY;
            rdata_ff <= {`DCAR_DATA_W{1'b0}};
        end else begin
            if (ar_hs) begin
                arready_ff <= 1'b0;
                rvalid_ff <= 1'b1;
                rdata_ff <= rd_mux;
                rresp_ff <= rd_hit ? `DCAR_RESP_OKAY : `DCAR_RESP_SLVERR;
            end
            if (rvalid_ff & s_axi_rready) begin
                rvalid_ff <= 1'b0;
                arready_ff <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs, all straight from flops

    assign s_axi_awready = awready_ff;
    assign s_axi_wready = wready_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rresp = rresp_ff;
    assign s_axi_rdata = rdata_ff;
    assign alarm_output_pin_o = pin_o_ff;
    assign alarm_output_pin_oe = pin_oe_ff;
    assign dac_clear = dac_clear_ff;

endmodule

`default_nettype wire

// ### hw/dcar_consts.vh
// register indices, field positions and reset values of the clear and alarm routing block
`ifndef DCAR_CONSTS_VH
`define DCAR_CONSTS_VH

// register indices; the byte address on the bus is four times the index
`define DCAR_IDX_GPIO_CFG 8'h12
`define DCAR_IDX_CLREN_LO 8'h18
`define DCAR_IDX_CLREN_HI 8'h19
`define DCAR_IDX_CSRC_ADC 8'h1a
`define DCAR_IDX_CSRC_MISC 8'h1b
`define DCAR_IDX_PSRC_ADC 8'h1c
`define DCAR_IDX_PSRC_MISC 8'h1d
`define DCAR_IDX_FLAGS 8'h20
`define DCAR_IDX_CLR_STATE 8'h21

// bus widths
`define DCAR_ADDR_W 8
`define DCAR_DATA_W 32

// field positions
`define DCAR_BIT_PIN_FN_EN 1
`define DCAR_BIT_LATCH_DIS 4
`define DCAR_ADC_ALARMS 5
`define DCAR_MISC_ALARMS 4
`define DCAR_ALL_ALARMS 9
`define DCAR_DACS 16

// implemented-bit masks; reserved bits read as zero
`define DCAR_MASK_CSRC_ADC 8'h1f
`define DCAR_MASK_CSRC_MISC 8'h0f
`define DCAR_MASK_PSRC_ADC 8'h1f

// reset value of every routing register
`define DCAR_RST_REG 8'h00

// bus responses
`define DCAR_RESP_OKAY 2'h0
`define DCAR_RESP_SLVERR 2'h2

`endif

// ### hw/dcar_flags.v
// per-alarm sticky flags with read-to-clear and latch-disable behaviour
`timescale 1ns/1ps
`default_nettype none

module dcar_flags #(
    parameter N = 9
) (
    // clock and reset
    input wire clk,
    input wire sys_rst,
    // control
    input wire latch_dis,
    input wire read_clr,
    // alarm conditions, same clock domain
    input wire [N-1:0] cond,
    // flag state
    output wire [N-1:0] flags
);

    reg [N-1:0] flag_ff;

    genvar i;
    generate
        for (i = 0; i < N; i = i + 1) begin : g_flag
            wire nxt_flag;
            // a live condition always sets; the set beats a read in the same cycle
            assign nxt_flag = cond[i] |
                (flag_ff[i] & ~latch_dis & ~read_clr);
            always @(posedge clk) begin
                if (sys_rst) begin
                    flag_ff[i] <= 1'b0;
                end else begin
                    flag_ff[i] <= nxt_flag;
                end
            end
        end
    endgenerate

    assign flags = flag_ff;

endmodule

`default_nettype wire

// ### sim/dcar_top_properties.sv
// checker for bus timing and clear routing of dcar_top
`timescale 1ns/1ps
`default_nettype none
`include "dcar_consts.vh"
module dcar_top_properties (
    // clock and reset
    input wire clk,
    input wire sys_rst,
    // bus
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [`DCAR_DATA_W-1:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    // alarm causes
    input wire [`DCAR_ADC_ALARMS-1:0] adc_alarm_cond,
    input wire thermal_alarm_cond,
    input wire local_temp_high_cond,
    input wire local_temp_low_cond,
    input wire alarm_input_pin,
    // outputs
    input wire alarm_output_pin_oe,
    input wire [`DCAR_DACS-1:0] dac_clear
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    //////////////////////////////////////////////////////////////////////////
    // cycles since a possible clear cause; writes count, since a latched
    // flag may meet a freshly written enable
    wire cause = |adc_alarm_cond | thermal_alarm_cond | local_temp_high_cond
        | local_temp_low_cond | alarm_input_pin | s_axi_bvalid;
    logic [3:0] since_ff;
    wire [3:0] nxt_since = cause ? 4'h0 : (since_ff == 4'hf ? since_ff : since_ff + 4'h1);
    always @(posedge clk) begin
        since_ff <= sys_rst ? 4'hf : nxt_since;
    end
    //////////////////////////////////////////////////////////////////////////
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    // the register is written and the response raised on the same edge, the
    // first one after both halves are taken
    property p_write_answer;
        s_wr_taken |-> ##2 s_axi_bvalid
            && (s_axi_bresp == `DCAR_RESP_OKAY || s_axi_bresp == `DCAR_RESP_SLVERR);
    endproperty
    property p_read_answer;
        s_rd_taken |=> s_axi_rvalid;
    endproperty
    property p_wr_release;
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready && s_axi_wready;
    endproperty
    property p_rd_release;
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready;
    endproperty
    property p_wr_refuse;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    property p_rd_refuse;
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    property p_slverr_zero;
        s_axi_rvalid && s_axi_rresp == `DCAR_RESP_SLVERR |-> s_axi_rdata == 32'h0;
    endproperty
    property p_clear_cause;
        $rose(|dac_clear) |-> since_ff <= 4'h8;
    endproperty
    property p_rst_quiet;
        disable iff (1'b0) sys_rst |=> dac_clear == 16'h0 && !alarm_output_pin_oe;
    endproperty
    a_write_answer: assert property (p_write_answer) else $error("no write response");
    a_read_answer: assert property (p_read_answer) else $error("no read data");
    a_wr_release: assert property (p_wr_release) else $error("write not released");
    a_rd_release: assert property (p_rd_release) else $error("read not released");
    a_wr_refuse: assert property (p_wr_refuse) else $error("write taken while busy");
    a_rd_refuse: assert property (p_rd_refuse) else $error("read taken while busy");
    a_slverr_zero: assert property (p_slverr_zero) else $error("error read not zero");
    a_clear_cause: assert property (p_clear_cause) else $error("no clear cause");
    a_rst_quiet: assert property (p_rst_quiet) else $error("busy after reset");
endmodule
bind dcar_top dcar_top_properties u_props (.clk(clk), .sys_rst(sys_rst),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .adc_alarm_cond(adc_alarm_cond), .thermal_alarm_cond(thermal_alarm_cond),
    .local_temp_high_cond(local_temp_high_cond), .local_temp_low_cond(local_temp_low_cond),
    .alarm_input_pin(alarm_input_pin), .alarm_output_pin_oe(alarm_output_pin_oe),
    .dac_clear(dac_clear));
`default_nettype wire

// ### sim/dac_clear_alarm_routing_test.sv
// self-checking bench for the clear and alarm routing block
`timescale 1ns/1ps
`default_nettype none
`include "dcar_consts.vh"
module dac_clear_alarm_routing_test;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic [4:0] adc_alarm_cond = 5'h0;
    logic thermal_alarm_cond = 1'b0;
    logic local_temp_high_cond = 1'b0;
    logic local_temp_low_cond = 1'b0;
    logic alarm_input_pin = 1'b0;
    logic general_io_one_o = 1'b0;
    logic general_io_one_oe = 1'b0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire alarm_output_pin_o, alarm_output_pin_oe;
    wire [15:0] dac_clear;
    wire [17:0] pins = {alarm_output_pin_oe, alarm_output_pin_o, dac_clear};
    int fail_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    logic [7:0] regs [7] = '{`DCAR_IDX_GPIO_CFG, `DCAR_IDX_CLREN_LO, `DCAR_IDX_CLREN_HI,
        `DCAR_IDX_CSRC_ADC, `DCAR_IDX_CSRC_MISC, `DCAR_IDX_PSRC_ADC, `DCAR_IDX_PSRC_MISC};
    logic [7:0] masks [7] = '{8'h02, 8'hff, 8'hff, 8'h1f, 8'h0f, 8'h1f, 8'h10};
    dcar_top u_dut (.clk(clk), .sys_rst(sys_rst), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .adc_alarm_cond(adc_alarm_cond),
        .thermal_alarm_cond(thermal_alarm_cond), .local_temp_high_cond(local_temp_high_cond),
        .local_temp_low_cond(local_temp_low_cond), .alarm_input_pin(alarm_input_pin),
        .general_io_one_o(general_io_one_o), .general_io_one_oe(general_io_one_oe),
        .alarm_output_pin_o(alarm_output_pin_o), .alarm_output_pin_oe(alarm_output_pin_oe),
        .dac_clear(dac_clear));
    //////////////////////////////////////////////////////////////////////////
    // 25 mhz clock and a cycle ceiling well above the expected run
    always #20 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            give_verdict();
        end
    end
    //////////////////////////////////////////////////////////////////////////
    task automatic chk_bus(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: bus gave %h, wanted %h", $time, got, exp);
        end
    endtask
    task automatic chk_pin(input logic [17:0] exp);
        samples_checked++;
        if (pins !== exp) begin
            fail_count++;
            $display("unexpected at %0t: pins %h, wanted %h", $time, pins, exp);
        end
    endtask
    // address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
        logic pa, pw, ta, tw;
        pa = 1'b1;
        pw = 1'b1;
        @(posedge clk);
        s_axi_awaddr <= {idx[5:0], 2'b00};
        s_axi_wdata <= {24'ha5c3e1, d}; // upper bits must be ignored
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (pa || pw) begin
            @(negedge clk);
            ta = pa && s_axi_awready;
            tw = pw && s_axi_wready;
            @(posedge clk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            pa = pa && !ta;
            pw = pw && !tw;
        end
        do @(negedge clk); while (!s_axi_bvalid);
        chk_bus({30'h0, s_axi_bresp}, {30'h0, er});
        @(posedge clk);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] idx, input logic [31:0] ed, input logic [1:0] er);
        @(posedge clk);
        s_axi_araddr <= {idx[5:0], 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(negedge clk); while (!s_axi_arready);
        @(posedge clk);
        s_axi_arvalid <= 1'b0;
        do @(negedge clk); while (!s_axi_rvalid);
        chk_bus(s_axi_rdata, ed);
        chk_bus({30'h0, s_axi_rresp}, {30'h0, er});
        @(posedge clk);
        s_axi_rready <= 1'b0;
    endtask
    // conditions in flag-word order: external, thermal, high, low, inputs
    task automatic setc(input logic [8:0] v);
        @(posedge clk);
        {alarm_input_pin, thermal_alarm_cond, local_temp_high_cond, local_temp_low_cond,
            adc_alarm_cond} <= v;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic give_verdict;
        $display("comparisons %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    //////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        foreach (regs[i]) rd(regs[i], 32'h0, `DCAR_RESP_OKAY);
        // all ones written; unimplemented bits read back as zero
        foreach (regs[i]) begin
            wr(regs[i], 8'hff, `DCAR_RESP_OKAY);
            rd(regs[i], {24'h0, masks[i]}, `DCAR_RESP_OKAY);
            wr(regs[i], 8'h00, `DCAR_RESP_OKAY);
        end
        // a write without byte lane 0 is answered but changes nothing
        s_axi_wstrb <= 4'he;
        wr(`DCAR_IDX_CLREN_LO, 8'h81, `DCAR_RESP_OKAY);
        s_axi_wstrb <= 4'hf;
        rd(`DCAR_IDX_CLREN_LO, 32'h0, `DCAR_RESP_OKAY);
        rd(8'h30, 32'h0, `DCAR_RESP_SLVERR);
        wr(`DCAR_IDX_FLAGS, 8'h01, `DCAR_RESP_SLVERR);
        wr(`DCAR_IDX_CLREN_LO, 8'h81, `DCAR_RESP_OKAY);
        wr(`DCAR_IDX_CLREN_HI, 8'h81, `DCAR_RESP_OKAY);
        // an unselected alarm clears nothing
        setc(9'h080);
        cyc(4);
        chk_pin(18'h0);
        setc(9'h000);
        rd(`DCAR_IDX_FLAGS, 32'h080, `DCAR_RESP_OKAY);
        // each source in turn; only dacs 0, 7, 8, 15 enabled
        for (int i = 0; i < 9; i++) begin
            logic [7:0] ri;
            ri = i < 5 ? `DCAR_IDX_CSRC_ADC : `DCAR_IDX_CSRC_MISC;
            wr(ri, 8'(1 << (i < 5 ? i : i - 5)), `DCAR_RESP_OKAY);
            setc(9'(1 << i));
            cyc(8);
            chk_pin({2'b00, 16'h8181});
            rd(`DCAR_IDX_FLAGS, 32'(1 << i), `DCAR_RESP_OKAY);
            setc(9'h000);
            cyc(8);
            chk_pin({2'b00, 16'h8181});
            rd(`DCAR_IDX_CLR_STATE, 32'h8181, `DCAR_RESP_OKAY);
            rd(`DCAR_IDX_FLAGS, 32'(1 << i), `DCAR_RESP_OKAY);
            cyc(4);
            chk_pin(18'h0);
            wr(ri, 8'h00, `DCAR_RESP_OKAY);
        end
        // shared pin stays general io until its alarm function is on
        wr(`DCAR_IDX_PSRC_ADC, 8'h04, `DCAR_RESP_OKAY);
        @(posedge clk);
        general_io_one_o <= 1'b1;
        general_io_one_oe <= 1'b1;
        setc(9'h004);
        cyc(4);
        chk_pin({2'b11, 16'h0});
        @(posedge clk);
        general_io_one_o <= 1'b0;
        cyc(3);
        chk_pin({2'b10, 16'h0});
        wr(`DCAR_IDX_GPIO_CFG, 8'h02, `DCAR_RESP_OKAY);
        cyc(3);
        chk_pin({2'b11, 16'h0});
        wr(`DCAR_IDX_PSRC_MISC, 8'h10, `DCAR_RESP_OKAY);
        setc(9'h000);
        cyc(4);
        chk_pin({2'b10, 16'h0});
        give_verdict();
    end
endmodule
`default_nettype wire
